//--- src/csb_consts.svh
// constants of the store, bit and flag execution unit
// Summary of operation
// - displaced write to pointer plus offset, one cycle
// - post-increment write uses pointer, then increments it
// - pre-decrement write decrements pointer, then writes
// - program memory read from Z, three cycles
// - I/O in and out take one cycle
// - push stores register on stack, one cycle
// - pop loads register from stack, two cycles
// - rotate left through carry, flags Z C N V H
// - rotate right through carry, flags Z C N V
// - I/O bit set forces one bit high
// - I/O bit clear forces one bit low
// - register bit copied into T flag only
// - T flag copied into register bit
// - overflow flag set or clear, one cycle
// - signed flag set or clear, one cycle
// - half carry flag set or clear, one cycle
// - nonvolatile memory access adds at least one cycle
// - busy memory controller may stall access longer
`ifndef CSB_CONSTS_SVH
`define CSB_CONSTS_SVH

`define CSB_ADDR_CMD      12'h000
`define CSB_ADDR_OPER     12'h004
`define CSB_ADDR_STATUS_FLAG_REGISTER     12'h008
`define CSB_ADDR_SP       12'h00C
`define CSB_ADDR_GPR_SEL  12'h010
`define CSB_ADDR_GPR_DATA 12'h014
`define CSB_ADDR_CYCLES   12'h018

`define CSB_CMD_OP        4:0
`define CSB_CMD_BUSY      8
`define CSB_OP_LAST       5'h19
`define CSB_OPER_RD       4:0
`define CSB_OPER_RR       12:8
`define CSB_OPER_BIT      18:16
`define CSB_OPER_PTR      21:20
`define CSB_OPER_MODE     23:22
`define CSB_OPER_DISP     29:24

`define CSB_F_C 0
`define CSB_F_Z 1
`define CSB_F_N 2
`define CSB_F_V 3
`define CSB_F_S 4
`define CSB_F_H 5
`define CSB_F_T 6

`define CSB_PTR_Z         2'h2
`define CSB_PTR_BASE      5'h1A
`define CSB_MODE_POST     2'h1
`define CSB_MODE_PRE      2'h2

`define CSB_CYC_ONE       2'h1
`define CSB_CYC_POP       2'h2
`define CSB_CYC_PM        2'h3
`define CSB_NVM_BASE      16'h1000
`define CSB_SP_RESET      16'h00FF
`define CSB_STATUS_FLAG_REGISTER_RESET    8'h00

`endif

//--- src/csb_pkg.sv
// types of the store, bit and flag execution unit
package csb_pkg;

	typedef enum logic [4:0] {
		op_nop,
		op_pointer_indirect_write,
		op_displaced_pointer_write,
		op_program_memory_read_r0,
		op_program_memory_read,
		op_program_memory_read_inc,
		op_io_in,
		op_io_out,
		op_push,
		op_pop,
		op_rotate_left_via_carry,
		op_rotate_right_via_carry,
		op_logical_left_shift,
		op_logical_right_shift,
		op_arith_right_shift,
		op_nibble_swap,
		op_io_bit_set,
		op_io_bit_clear,
		op_reg_bit_to_t_flag,
		op_t_flag_to_reg_bit,
		op_generic_flag_set,
		op_generic_flag_clear,
		op_overflow_flag_set,
		op_overflow_flag_clear,
		op_signed_flag_set,
		op_half_carry_set
	} csb_op_t;

	typedef enum logic {st_idle, st_run} csb_state_t;

endpackage

//--- src/csb_shift_unit.sv
// shift, rotate and nibble swap datapath with flag results
`timescale 1ns/1ns
`include "csb_consts.svh"
module csb_shift_unit
	import csb_pkg::*;
(
	input  wire logic [4:0] op,
	input  wire logic [7:0] value,
	input  wire logic       carry,
	output logic      [7:0] result,
	output logic      [7:0] flags,
	output logic      [7:0] mask
);
	logic cout;

	always_comb begin
		result = value;
		cout   = carry;
		mask   = 8'h00;
		case (csb_op_t'(op))
			op_rotate_left_via_carry: begin
				result = {value[6:0], carry};
				cout   = value[7];
				mask   = 8'h2F;
			end
			op_logical_left_shift: begin
				result = {value[6:0], 1'b0};
				cout   = value[7];
				mask   = 8'h2F;
			end
			op_rotate_right_via_carry: begin
				result = {carry, value[7:1]};
				cout   = value[0];
				mask   = 8'h0F;
			end
			op_logical_right_shift: begin
				result = {1'b0, value[7:1]};
				cout   = value[0];
				mask   = 8'h0F;
			end
			op_arith_right_shift: begin
				result = {value[7], value[7:1]};
				cout   = value[0];
				mask   = 8'h0F;
			end
			op_nibble_swap: begin
				result = {value[3:0], value[7:4]};
			end
			default: begin
				result = value;
			end
		endcase
		flags             = 8'h00;
		flags[`CSB_F_C]   = cout;
		flags[`CSB_F_Z]   = (result == 8'h00);
		flags[`CSB_F_N]   = result[7];
		flags[`CSB_F_V]   = result[7] ^ cout;
		// half carry after a left shift is the old bit 3
		flags[`CSB_F_H]   = value[3];
	end

endmodule

//--- src/csb_exec.sv
// execution unit for stores, program memory reads, I/O, stack, shifts and flag ops
//
// Added by the designer: the address map and the APB register port.
`timescale 1ns/1ns
`include "csb_consts.svh"
module csb_exec
	import csb_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	output logic      [15:0] dm_addr,
	output logic      [7:0]  dm_wdata,
	output logic             dm_we,
	output logic             dm_re,
	input  wire logic [7:0]  dm_rdata,
	input  wire logic        dm_ready,
	output logic      [15:0] pm_addr,
	input  wire logic [7:0]  pm_rdata,
	output logic      [5:0]  io_addr,
	output logic      [7:0]  io_wdata,
	output logic             io_we,
	output logic             io_re,
	input  wire logic [7:0]  io_rdata,
	output logic             io_bit_we,
	output logic      [2:0]  io_bit_idx,
	output logic             io_bit_val,
	output logic             busy
);
	logic [7:0]  gpr [32];
	logic [7:0]  status_flag_register;
	logic [15:0] sp;
	csb_op_t     op_q;
	csb_state_t  state;
	logic [1:0]  cnt;
	logic        nvm_q;
	logic        extra_q;
	logic [7:0]  run_cyc;
	logic [7:0]  cycles_q;
	logic [4:0]  gpr_sel;
	logic [4:0]  opr_rd;
	logic [4:0]  opr_rr;
	logic [2:0]  opr_bit;
	logic [1:0]  opr_ptr;
	logic [1:0]  opr_mode;
	logic [5:0]  opr_disp;
	logic [15:0] addr_q;

	logic        setup_ph;
	logic        access_ph;
	logic        wr_ok;
	logic        start;
	logic        last;
	logic        done;
	logic        mem_op;
	logic        acc_ok;
	csb_op_t     new_op;
	logic [15:0] next_addr;
	logic [1:0]  next_cnt;
	logic [4:0]  ptr_lo;
	logic [15:0] ptr_cur;
	logic [15:0] ptr_zv;
	logic [7:0]  op_val;
	logic [7:0]  src_val;
	logic [7:0]  sh_res;
	logic [7:0]  sh_flags;
	logic [7:0]  sh_mask;

	function automatic logic mapped(input logic [11:0] a);
		mapped = (a == `CSB_ADDR_CMD) || (a == `CSB_ADDR_OPER) ||
			(a == `CSB_ADDR_STATUS_FLAG_REGISTER) || (a == `CSB_ADDR_SP) ||
			(a == `CSB_ADDR_GPR_SEL) || (a == `CSB_ADDR_GPR_DATA) ||
			(a == `CSB_ADDR_CYCLES);
	endfunction

	function automatic logic [4:0] ptr_idx(input logic [1:0] sel);
		ptr_idx = `CSB_PTR_BASE + {2'b00, sel, 1'b0};
	endfunction

	function automatic logic is_mem(input csb_op_t op);
		is_mem = (op == op_pointer_indirect_write) || (op == op_displaced_pointer_write) ||
			(op == op_push) || (op == op_pop);
	endfunction

	// apb: zero wait states, read data captured in the setup cycle
	assign setup_ph  = psel & ~penable;
	assign access_ph = psel & penable;
	assign pready    = 1'b1;
	assign pslverr   = access_ph & ~mapped(paddr);
	// state writes are refused while an operation runs
	assign wr_ok     = access_ph & pwrite & ~busy;
	assign start     = wr_ok & (paddr == `CSB_ADDR_CMD);
	assign new_op    = (pwdata[`CSB_CMD_OP] <= `CSB_OP_LAST) ?
		csb_op_t'(pwdata[`CSB_CMD_OP]) : op_nop;
	assign busy      = (state == st_run);

	assign ptr_lo  = ptr_idx(opr_ptr);
	assign ptr_cur = {gpr[ptr_lo + 5'h01], gpr[ptr_lo]};
	assign ptr_zv  = {gpr[ptr_idx(`CSB_PTR_Z) + 5'h01], gpr[ptr_idx(`CSB_PTR_Z)]};
	assign op_val  = gpr[opr_rd];
	// bit store reads the source operand, not the destination
	assign src_val = gpr[opr_rr];

	always_comb begin
		next_addr = 16'h0000;
		next_cnt  = `CSB_CYC_ONE;
		case (new_op)
			op_pointer_indirect_write: begin
				next_addr = (opr_mode == `CSB_MODE_PRE) ? ptr_cur - 16'h0001 : ptr_cur;
			end
			op_displaced_pointer_write: begin
				next_addr = ptr_cur + {10'h000, opr_disp};
			end
			op_push: begin
				next_addr = sp;
			end
			op_pop: begin
				next_addr = sp + 16'h0001;
				next_cnt  = `CSB_CYC_POP;
			end
			op_program_memory_read_r0, op_program_memory_read, op_program_memory_read_inc: begin
				next_addr = ptr_zv;
				next_cnt  = `CSB_CYC_PM;
			end
			default: begin
				next_addr = 16'h0000;
			end
		endcase
	end

	// sequencer: last counted cycle holds while a slow memory access completes
	assign last   = busy & (cnt == 2'h0);
	assign mem_op = is_mem(op_q);
	assign acc_ok = ~nvm_q | (extra_q & dm_ready);
	assign done   = last & (~mem_op | acc_ok);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state   <= st_idle;
			cnt     <= 2'h0;
			extra_q <= 1'b0;
		end else begin
			unique case (state)
				st_idle: begin
					if (start) begin
						state   <= st_run;
						cnt     <= 2'(next_cnt - 2'h1);
						extra_q <= 1'b0;
					end
				end
				st_run: begin
					if (done) begin
						state <= st_idle;
					end else if (last) begin
						extra_q <= 1'b1;
					end else begin
						cnt <= 2'(cnt - 2'h1);
					end
				end
			endcase
		end
	end

	// operands of the access are frozen at start
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			op_q       <= op_nop;
			addr_q     <= 16'h0000;
			nvm_q      <= 1'b0;
			dm_wdata   <= 8'h00;
			io_wdata   <= 8'h00;
			io_bit_val <= 1'b0;
		end else if (start) begin
			op_q       <= new_op;
			addr_q     <= next_addr;
			nvm_q      <= is_mem(new_op) && (next_addr >= `CSB_NVM_BASE);
			dm_wdata   <= gpr[opr_rr];
			io_wdata   <= gpr[opr_rr];
			io_bit_val <= (new_op == op_io_bit_set);
		end
	end

	assign dm_addr    = addr_q;
	assign pm_addr    = addr_q;
	assign io_addr    = opr_disp;
	assign io_bit_idx = opr_bit;
	// stores hold their strobe through any memory controller wait
	assign dm_we      = last & (op_q != op_pop) & mem_op;
	assign dm_re      = last & (op_q == op_pop);
	assign io_we      = busy & (op_q == op_io_out);
	assign io_re      = busy & (op_q == op_io_in);
	assign io_bit_we  = busy & ((op_q == op_io_bit_set) || (op_q == op_io_bit_clear));

	csb_shift_unit u_shift (
		.op     (op_q),
		.value  (op_val),
		.carry  (status_flag_register[`CSB_F_C]),
		.result (sh_res),
		.flags  (sh_flags),
		.mask   (sh_mask)
	);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < 32; i++) begin
				gpr[i] <= 8'h00;
			end
		end else if (wr_ok && paddr == `CSB_ADDR_GPR_DATA) begin
			gpr[gpr_sel] <= pwdata[7:0];
		end else if (done) begin
			case (op_q)
				op_pointer_indirect_write: begin
					if (opr_mode == `CSB_MODE_POST) begin
						gpr[ptr_lo]         <= 8'(ptr_cur + 16'h0001);
						gpr[ptr_lo + 5'h01] <= 8'((ptr_cur + 16'h0001) >> 8);
					end else if (opr_mode == `CSB_MODE_PRE) begin
						gpr[ptr_lo]         <= addr_q[7:0];
						gpr[ptr_lo + 5'h01] <= addr_q[15:8];
					end
				end
				op_program_memory_read_r0: begin
					gpr[0] <= pm_rdata;
				end
				op_program_memory_read: begin
					gpr[opr_rd] <= pm_rdata;
				end
				op_program_memory_read_inc: begin
					gpr[opr_rd] <= pm_rdata;
					// pointer update wins when the destination overlaps Z
					gpr[ptr_idx(`CSB_PTR_Z)]         <= 8'(addr_q + 16'h0001);
					gpr[ptr_idx(`CSB_PTR_Z) + 5'h01] <= 8'((addr_q + 16'h0001) >> 8);
				end
				op_io_in: begin
					gpr[opr_rd] <= io_rdata;
				end
				op_pop: begin
					gpr[opr_rd] <= dm_rdata;
				end
				op_rotate_left_via_carry, op_rotate_right_via_carry, op_logical_left_shift,
				op_logical_right_shift, op_arith_right_shift, op_nibble_swap: begin
					gpr[opr_rd] <= sh_res;
				end
				op_t_flag_to_reg_bit: begin
					gpr[opr_rd][opr_bit] <= status_flag_register[`CSB_F_T];
				end
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			status_flag_register <= `CSB_STATUS_FLAG_REGISTER_RESET;
		end else if (wr_ok && paddr == `CSB_ADDR_STATUS_FLAG_REGISTER) begin
			status_flag_register <= pwdata[7:0];
		end else if (done) begin
			case (op_q)
				op_rotate_left_via_carry, op_rotate_right_via_carry, op_logical_left_shift,
				op_logical_right_shift, op_arith_right_shift: begin
					status_flag_register <= (status_flag_register & ~sh_mask) | (sh_flags & sh_mask);
				end
				op_reg_bit_to_t_flag:   status_flag_register[`CSB_F_T] <= src_val[opr_bit];
				op_generic_flag_set:    status_flag_register[opr_bit]  <= 1'b1;
				op_generic_flag_clear:  status_flag_register[opr_bit]  <= 1'b0;
				op_overflow_flag_set:   status_flag_register[`CSB_F_V] <= 1'b1;
				op_overflow_flag_clear: status_flag_register[`CSB_F_V] <= 1'b0;
				op_signed_flag_set:     status_flag_register[`CSB_F_S] <= opr_bit[0];
				op_half_carry_set:      status_flag_register[`CSB_F_H] <= opr_bit[0];
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sp <= `CSB_SP_RESET;
		end else if (wr_ok && paddr == `CSB_ADDR_SP) begin
			sp <= pwdata[15:0];
		end else if (done && op_q == op_push) begin
			sp <= sp - 16'h0001;
		end else if (done && op_q == op_pop) begin
			sp <= addr_q;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			gpr_sel  <= 5'h00;
			opr_rd   <= 5'h00;
			opr_rr   <= 5'h00;
			opr_bit  <= 3'h0;
			opr_ptr  <= 2'h0;
			opr_mode <= 2'h0;
			opr_disp <= 6'h00;
		end else if (wr_ok && paddr == `CSB_ADDR_OPER) begin
			opr_rd   <= pwdata[`CSB_OPER_RD];
			opr_rr   <= pwdata[`CSB_OPER_RR];
			opr_bit  <= pwdata[`CSB_OPER_BIT];
			opr_ptr  <= pwdata[`CSB_OPER_PTR];
			opr_mode <= pwdata[`CSB_OPER_MODE];
			opr_disp <= pwdata[`CSB_OPER_DISP];
		end else if (wr_ok && paddr == `CSB_ADDR_GPR_SEL) begin
			gpr_sel <= pwdata[4:0];
		end
	end

	// cycle count of the last operation, including controller waits
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			run_cyc  <= 8'h00;
			cycles_q <= 8'h00;
		end else if (start) begin
			run_cyc <= 8'h01;
		end else if (done) begin
			cycles_q <= run_cyc;
		end else if (busy && run_cyc != 8'hFF) begin
			run_cyc <= 8'(run_cyc + 8'h01);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (setup_ph) begin
			case (paddr)
				`CSB_ADDR_CMD:      prdata <= {23'h000000, busy, 3'h0, op_q};
				`CSB_ADDR_OPER:     prdata <= {2'h0, opr_disp, opr_mode, opr_ptr, 1'b0,
					opr_bit, 3'h0, opr_rr, 3'h0, opr_rd};
				`CSB_ADDR_STATUS_FLAG_REGISTER:     prdata <= {24'h000000, status_flag_register};
				`CSB_ADDR_SP:       prdata <= {16'h0000, sp};
				`CSB_ADDR_GPR_SEL:  prdata <= {27'h0000000, gpr_sel};
				`CSB_ADDR_GPR_DATA: prdata <= {24'h000000, gpr[gpr_sel]};
				`CSB_ADDR_CYCLES:   prdata <= {24'h000000, cycles_q};
				default:            prdata <= 32'h0000_0000;
			endcase
		end
	end

	AST_PM_THREE: assert property (@(posedge pclk) disable iff (!presetn)
		start && new_op == op_program_memory_read |=> !done ##1 !done ##1 done)
		else $error("program memory read not three cycles");

	AST_POP_TWO: assert property (@(posedge pclk) disable iff (!presetn)
		start && new_op == op_pop |=> !done && !dm_re ##1 done && dm_re)
		else $error("pop not two cycles");

	AST_PUSH_ONE: assert property (@(posedge pclk) disable iff (!presetn)
		start && new_op == op_push && next_addr < `CSB_NVM_BASE |=> done && dm_we
		##1 sp == $past(sp, 2) - 16'h0001)
		else $error("push not one cycle or stack pointer wrong");

	AST_NVM_EXTRA: assert property (@(posedge pclk) disable iff (!presetn)
		start && is_mem(new_op) && next_addr >= `CSB_NVM_BASE |=> !done)
		else $error("nonvolatile access finished without extra cycle");

	AST_NVM_STALL: assert property (@(posedge pclk) disable iff (!presetn)
		last && nvm_q && extra_q && !dm_ready |-> !done ##1 busy)
		else $error("access finished while controller busy");

	AST_POST_INC: assert property (@(posedge pclk) disable iff (!presetn)
		done && op_q == op_pointer_indirect_write && opr_mode == `CSB_MODE_POST
		|-> dm_addr == ptr_cur ##1 ptr_cur == $past(dm_addr) + 16'h0001)
		else $error("post-increment pointer wrong");

	AST_ROL_FLAGS: assert property (@(posedge pclk) disable iff (!presetn)
		done && op_q == op_rotate_left_via_carry |=> status_flag_register[`CSB_F_C] == $past(op_val[7])
		&& op_val[0] == $past(status_flag_register[`CSB_F_C]) && status_flag_register[`CSB_F_H] == $past(op_val[3]))
		else $error("rotate left result or flags wrong");

	AST_ROR_FLAGS: assert property (@(posedge pclk) disable iff (!presetn)
		done && op_q == op_rotate_right_via_carry |=> status_flag_register[`CSB_F_C] == $past(op_val[0])
		&& op_val[7] == $past(status_flag_register[`CSB_F_C]) && $stable(status_flag_register[`CSB_F_H]))
		else $error("rotate right result or flags wrong");

	AST_BIT_TO_T: assert property (@(posedge pclk) disable iff (!presetn)
		done && op_q == op_reg_bit_to_t_flag |=> status_flag_register[`CSB_F_T] == $past(src_val[opr_bit])
		&& status_flag_register[5:0] == $past(status_flag_register[5:0]) && status_flag_register[7] == $past(status_flag_register[7]))
		else $error("bit store changed more than T");

	AST_FLAGS_KEPT: assert property (@(posedge pclk) disable iff (!presetn)
		done && (mem_op || op_q == op_io_in || op_q == op_io_out || op_q == op_io_bit_set
		|| op_q == op_io_bit_clear || op_q == op_t_flag_to_reg_bit) |=> $stable(status_flag_register))
		else $error("status flags changed by transfer");

	AST_IO_BIT: assert property (@(posedge pclk) disable iff (!presetn)
		start && (new_op == op_io_bit_set || new_op == op_io_bit_clear)
		|=> io_bit_we && done && io_bit_val == (op_q == op_io_bit_set) ##1 !io_bit_we)
		else $error("io bit operation wrong");

	AST_V_ONLY: assert property (@(posedge pclk) disable iff (!presetn)
		done && op_q == op_overflow_flag_set |=> status_flag_register[`CSB_F_V]
		&& (status_flag_register & 8'hF7) == ($past(status_flag_register) & 8'hF7))
		else $error("overflow set touched other flags");

endmodule

//--- verification/csb_mem_model.sv
// far-side model: data memory, I/O space and program memory
`timescale 1ns/1ns
`include "csb_consts.svh"
module csb_mem_model (
	input  wire logic        pclk,
	input  wire logic [15:0] dm_addr,
	input  wire logic [7:0]  dm_wdata,
	input  wire logic        dm_we,
	input  wire logic        dm_re,
	output logic      [7:0]  dm_rdata,
	output logic             dm_ready,
	input  wire logic [15:0] pm_addr,
	output logic      [7:0]  pm_rdata,
	input  wire logic [5:0]  io_addr,
	input  wire logic [7:0]  io_wdata,
	input  wire logic        io_we,
	input  wire logic        io_re,
	output logic      [7:0]  io_rdata,
	input  wire logic        io_bit_we,
	input  wire logic [2:0]  io_bit_idx,
	input  wire logic        io_bit_val,
	input  wire logic [2:0]  nvm_wait
);
	logic [7:0] dmem [0:65535];
	logic [7:0] iomem [0:63];
	logic [7:0] dm_last;
	logic [7:0] io_last;
	logic [2:0] wcnt;
	logic       nonvolatile_memory;
	initial begin
		for (int i = 0; i < 65536; i++)
			dmem[i] = 8'h00;
		for (int i = 0; i < 64; i++)
			iomem[i] = 8'h00;
		dm_last = 8'h00;
		io_last = 8'h00;
		wcnt = 3'h0;
	end
	// an idle read line shows the inverse of its last value, never a stale copy
	assign dm_rdata = dm_re ? dmem[dm_addr] : ~dm_last;
	assign io_rdata = io_re ? iomem[io_addr] : ~io_last;
	assign pm_rdata = pm_addr[7:0] ^ pm_addr[15:8] ^ 8'hA5;
	// the controller region stalls for nvm_wait cycles counted from the first strobe
	assign nonvolatile_memory = (dm_we | dm_re) && dm_addr >= `CSB_NVM_BASE;
	assign dm_ready = !nonvolatile_memory || wcnt >= nvm_wait;
	always @(posedge pclk) begin
		wcnt <= nonvolatile_memory ? wcnt + {2'h0, wcnt != 3'h7} : 3'h0;
		if (dm_we && dm_ready)
			dmem[dm_addr] <= dm_wdata;
		if (dm_re)
			dm_last <= dm_rdata;
		if (io_re)
			io_last <= io_rdata;
		if (io_we)
			iomem[io_addr] <= io_wdata;
		if (io_bit_we)
			iomem[io_addr][io_bit_idx] <= io_bit_val;
	end
endmodule

//--- verification/tb_top.sv
// self-checking bench of the store, bit and flag execution unit
`timescale 1ns/1ns
`include "csb_consts.svh"
module tb_top;
	import csb_pkg::*;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, busy, err;
	logic        dm_we, dm_re, dm_ready, io_we, io_re, io_bit_we, io_bit_val;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, seed;
	logic [15:0] dm_addr, pm_addr;
	logic [7:0]  dm_wdata, dm_rdata, pm_rdata, io_wdata, io_rdata, sr, cyc_got;
	logic [5:0]  io_addr;
	logic [2:0]  io_bit_idx, nvm_wait;
	int          bad_count, cmp_count;
	csb_exec dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .dm_addr, .dm_wdata, .dm_we, .dm_re, .dm_rdata, .dm_ready,
		.pm_addr, .pm_rdata, .io_addr, .io_wdata, .io_we, .io_re, .io_rdata, .io_bit_we,
		.io_bit_idx, .io_bit_val, .busy);
	csb_mem_model mem (.pclk, .dm_addr, .dm_wdata, .dm_we, .dm_re, .dm_rdata, .dm_ready,
		.pm_addr, .pm_rdata, .io_addr, .io_wdata, .io_we, .io_re, .io_rdata, .io_bit_we,
		.io_bit_idx, .io_bit_val, .nvm_wait);
	always #25 pclk = ~pclk;
	task automatic summarize();
		if (bad_count == 0 && cmp_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic tmo();
		bad_count++;
		summarize();
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			bad_count++;
			$display("[FAIL] %0t got %h want %h", $time, got, exp);
		end
	endtask
	task automatic chk_min(input logic [31:0] got, input logic [31:0] lo);
		cmp_count++;
		if ((got >= lo) !== 1'b1) begin
			bad_count++;
			$display("[FAIL] %0t got %h below %h", $time, got, lo);
		end
	endtask
	function automatic logic [31:0] rnd();
		seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
		return seed;
	endfunction
	function automatic logic [31:0] opr(input logic [4:0] d, s, input logic [2:0] b,
		input logic [1:0] pt, md, input logic [5:0] q);
		return {2'h0, q, md, pt, 1'h0, b, 3'h0, s, 3'h0, d};
	endfunction
	function automatic logic [15:0] shx(input int k, input logic [7:0] v, s);
		logic [7:0] r;
		case (k)
			10: r = {v[6:0], s[0]};
			11: r = {s[0], v[7:1]};
			12: r = {v[6:0], 1'b0};
			13: r = {1'b0, v[7:1]};
			14: r = {v[7], v[7:1]};
			default: r = {v[3:0], v[7:4]};
		endcase
		if (k != 15) begin
			s[0] = k == 10 || k == 12 ? v[7] : v[0];
			s[1] = r == 8'h00;
			s[2] = r[7];
			s[3] = r[7] ^ s[0];
			if (k == 10 || k == 12)
				s[5] = v[3];
		end
		return {s, r};
	endfunction
	function automatic logic [7:0] fx(input int k, input logic [2:0] b, input logic [7:0] s);
		case (k)
			20: s[b] = 1'b1;
			21: s[b] = 1'b0;
			22: s[3] = 1'b1;
			23: s[3] = 1'b0;
			24: s[4] = b[0];
			default: s[5] = b[0];
		endcase
		return s;
	endfunction
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] q);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		for (n = 0; n < 20; n++) begin
			@(posedge pclk);
			if (pready === 1'b1)
				break;
		end
		if (n == 20)
			tmo();
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] q;
		apb(1'b1, a, d, q);
	endtask
	task automatic rd(input logic [11:0] a, output logic [31:0] q);
		apb(1'b0, a, 32'h0, q);
	endtask
	task automatic sg(input logic [4:0] r, input logic [7:0] v);
		wr(`CSB_ADDR_GPR_SEL, {27'h0, r});
		wr(`CSB_ADDR_GPR_DATA, {24'h0, v});
	endtask
	task automatic gg(input logic [4:0] r, output logic [7:0] v);
		logic [31:0] q;
		wr(`CSB_ADDR_GPR_SEL, {27'h0, r});
		rd(`CSB_ADDR_GPR_DATA, q);
		v = q[7:0];
	endtask
	task automatic sp_(input logic [1:0] p, input logic [15:0] v);
		sg(`CSB_PTR_BASE + {2'h0, p, 1'b0}, v[7:0]);
		sg(`CSB_PTR_BASE + {2'h0, p, 1'b1}, v[15:8]);
	endtask
	task automatic gp(input logic [1:0] p, output logic [15:0] v);
		gg(`CSB_PTR_BASE + {2'h0, p, 1'b0}, v[7:0]);
		gg(`CSB_PTR_BASE + {2'h0, p, 1'b1}, v[15:8]);
	endtask
	// cyc 0 skips the exact cycle check; the flag byte is always compared
	task automatic run(input int op, input logic [31:0] o, input logic [7:0] cyc, fl);
		logic [31:0] q;
		int n;
		wr(`CSB_ADDR_OPER, o);
		wr(`CSB_ADDR_CMD, 32'(op));
		@(posedge pclk);
		chk(busy, 1);
		for (n = 0; n < 40 && busy !== 1'b0; n++)
			@(posedge pclk);
		if (n == 40)
			tmo();
		rd(`CSB_ADDR_CYCLES, q);
		cyc_got = q[7:0];
		if (cyc != 0)
			chk(q[7:0], cyc);
		rd(`CSB_ADDR_STATUS_FLAG_REGISTER, q);
		chk(q[7:0], fl);
		sr = fl;
	endtask
	initial begin
		logic [31:0] r, q;
		logic [15:0] p, e16, spv;
		logic [7:0]  v, e;
		logic [4:0]  rr, d;
		logic [1:0]  pt, md;
		logic [5:0]  a;
		logic [2:0]  b;
		pclk = 1'b0;
		presetn = 1'b0;
		{psel, penable, pwrite} = 3'h0;
		paddr = 12'h000;
		pwdata = 32'h0;
		nvm_wait = 3'h0;
		seed = 32'h06EC;
		bad_count = 0;
		cmp_count = 0;
		spv = `CSB_SP_RESET;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		rd(`CSB_ADDR_SP, q);
		chk(q, {16'h0, spv});
		rd(12'h020, q);
		chk({q[30:0], err}, 32'h1);
		for (int i = 0; i < 6; i++) begin
			r = rnd();
			v = i == 0 ? 8'h00 : i == 1 ? 8'h81 : r[31:24];
			// never r0: the program memory read to r0 would overwrite the source
			rr = {1'b0, r[3:1], 1'b1};
			d = 5'h10 + {2'h0, r[6:4]};
			p = 16'h0200 + {6'h0, r[17:8]};
			a = r[29:24];
			b = r[14:12];
			pt = 2'(i % 3);
			md = 2'((i + i / 3) % 3);
			sr = r[23:16];
			wr(`CSB_ADDR_STATUS_FLAG_REGISTER, {24'h0, sr});
			sp_(pt, p);
			sg(rr, v);
			run(1, opr(0, rr, 0, pt, md, 0), 1, sr);
			chk(mem.dmem[md == `CSB_MODE_PRE ? p - 1 : p], v);
			gp(pt, e16);
			chk(e16, md == `CSB_MODE_POST ? p + 1 : md == `CSB_MODE_PRE ? p - 1 : p);
			sp_(2'(1 + i % 2), p);
			run(2, opr(0, rr, 0, 2'(1 + i % 2), 0, a), 1, sr);
			chk(mem.dmem[p + a], v);
			for (int k = 3; k < 6; k++) begin
				sp_(2'h2, p);
				run(k, opr(d, 0, 0, 0, 0, 0), 3, sr);
				gg(k == 3 ? 5'h0 : d, e);
				chk(e, p[7:0] ^ p[15:8] ^ 8'hA5);
				gp(2'h2, e16);
				chk(e16, k == 5 ? p + 1 : p);
			end
			run(7, opr(0, rr, 0, 0, 0, a), 1, sr);
			chk(mem.iomem[a], v);
			run(6, opr(d, 0, 0, 0, 0, a), 1, sr);
			gg(d, e);
			chk(e, v);
			run(16, opr(0, 0, b, 0, 0, a), 1, sr);
			chk(mem.iomem[a], v | (8'h01 << b));
			run(17, opr(0, 0, ~b, 0, 0, a), 1, sr);
			chk(mem.iomem[a], (v | (8'h01 << b)) & ~(8'h01 << ~b));
			run(8, opr(0, rr, 0, 0, 0, 0), 1, sr);
			chk(mem.dmem[spv], v);
			run(9, opr(d, 0, 0, 0, 0, 0), 2, sr);
			gg(d, e);
			chk(e, v);
			rd(`CSB_ADDR_SP, q);
			chk(q, {16'h0, spv});
			for (int k = 10; k < 16; k++) begin
				sg(d, v ^ 8'(k));
				e16 = shx(k, v ^ 8'(k), sr);
				run(k, opr(d, 0, 0, 0, 0, 0), 1, e16[15:8]);
				gg(d, e);
				chk(e, e16[7:0]);
			end
			run(18, opr(0, rr, b, 0, 0, 0), 1, {sr[7], v[b], sr[5:0]});
			sg(d, v);
			run(19, opr(d, 0, ~b, 0, 0, 0), 1, sr);
			e = v;
			e[~b] = sr[6];
			gg(d, v);
			chk(v, e);
			for (int k = 20; k < 26; k++) begin
				b = 3'(rnd());
				run(k, opr(0, 0, b, 0, 0, 0), 1, fx(k, b, sr));
			end
		end
		// a register write while an operation runs must be dropped
		wr(`CSB_ADDR_OPER, opr(5'h10, 0, 0, 0, 0, 0));
		wr(`CSB_ADDR_CMD, 32'h4);
		wr(`CSB_ADDR_STATUS_FLAG_REGISTER, {24'h0, ~sr});
		rd(`CSB_ADDR_STATUS_FLAG_REGISTER, q);
		chk(q, {24'h0, sr});
		for (int w = 0; w < 6; w += 5) begin
			nvm_wait <= 3'(w);
			sp_(2'h0, `CSB_NVM_BASE + 16'(w));
			sg(5'h1, 8'(w) ^ 8'h3C);
			run(1, opr(0, 1, 0, 0, 0, 0), 0, sr);
			chk_min({24'h0, cyc_got}, w < 2 ? 2 : w + 1);
			chk(mem.dmem[`CSB_NVM_BASE + 16'(w)], 8'(w) ^ 8'h3C);
		end
		summarize();
	end
endmodule
